// ==== rtl/charger_ctrl_pkg.sv ====
// Constants, register layouts and types for the input source controller.
// Assumes a 50 MHz system clock; limits are coded in 100 mA steps.
package charger_ctrl_pkg;

	// Clock and timing
	localparam int CLK_HZ        = 50_000_000;
	localparam int REG_DELAY_MS  = 220;
	localparam int REG_DELAY_CYC = REG_DELAY_MS * (CLK_HZ / 1000);
	localparam int STAGE_MS      = 10;
	localparam int STAGE_CYC     = STAGE_MS * (CLK_HZ / 1000);
	localparam int SOFT_MS       = 2;
	localparam int SOFT_CYC      = SOFT_MS * (CLK_HZ / 1000);
	localparam int STEP_MS       = 5;
	localparam int STEP_CYC      = STEP_MS * (CLK_HZ / 1000);
	localparam int CNT_W         = 24;

	// Register byte offsets
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_CURLIM = 8'h04;
	localparam logic [7:0] ADR_VOLLIM = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0c;
	localparam logic [7:0] ADR_IRQ    = 8'h10;
	localparam logic [7:0] ADR_MASK   = 8'h14;

	// Current limit codes, 100 mA per step
	localparam int         LIM_W    = 6;
	localparam logic [5:0] LIM_500  = 6'h05;
	localparam logic [5:0] LIM_1A0  = 6'h0a;
	localparam logic [5:0] LIM_1A5  = 6'h0f;
	localparam logic [5:0] LIM_2A1  = 6'h15;
	localparam logic [5:0] LIM_2A4  = 6'h18;
	localparam logic [5:0] LIM_3A0  = 6'h1e;
	localparam logic [7:0] VLIM_RST = 8'h0e;

	// Source type codes
	localparam logic [2:0] SRC_NONE = 3'h0;
	localparam logic [2:0] SRC_SDP  = 3'h1;
	localparam logic [2:0] SRC_CDP  = 3'h2;
	localparam logic [2:0] SRC_DCP  = 3'h3;
	localparam logic [2:0] SRC_UNK  = 3'h5;
	localparam logic [2:0] SRC_DIV  = 3'h6;

	// Optimizer status codes
	localparam logic [1:0] OPT_OFF  = 2'h0;
	localparam logic [1:0] OPT_RUN  = 2'h1;
	localparam logic [1:0] OPT_DONE = 2'h2;

	// Interrupt status bits
	localparam int IRQ_W   = 3;
	localparam int IRQ_DET = 0;
	localparam int IRQ_OPT = 1;
	localparam int IRQ_PWR = 2;

	typedef struct packed {
		logic chargeEnable;
		logic dischargeSourceEnable;
		logic highImpedanceRequest;
		logic limitPinEnable;
		logic forceOptimizerBit;
		logic optimizerEnable;
		logic autoDetectionEnable;
		logic forceDetectionBit;
	} ctrl_t;
	localparam ctrl_t CTRL_RST = 8'h96;

	typedef struct packed {
		logic [9:0] zeroHi;
		logic [5:0] effectiveLimit;
		logic [1:0] zeroMid;
		logic [5:0] optimizerLimit;
		logic       highImpedanceMode;
		logic       regulatorOn;
		logic [1:0] optimizerStatus;
		logic       powerGoodFlag;
		logic [2:0] sourceTypeCode;
	} status_t;

	// Analog comparator results from the front end
	typedef struct packed {
		logic vbusPresent;
		logic vbusOvp;
		logic sourceGood;
		logic buckMode;
		logic dataContact;
		logic primaryHigh;
		logic secondaryHigh;
		logic dp2p8;
		logic dp2p0;
		logic dm2p8;
		logic dm2p0;
		logic batBelowSysMin;
		logic lightLoad;
		logic inVoltageLimit;
	} sense_t;

	typedef enum logic [4:0] {
		DET_IDLE = 5'b00001,
		DET_DCD  = 5'b00010,
		DET_PRI  = 5'b00100,
		DET_SEC  = 5'b01000,
		DET_FIN  = 5'b10000
	} det_state_t;

endpackage

// ==== rtl/input_source_ctrl.sv ====
// Input source detection, start-up gating and input current optimizer.
// Assumes comparator inputs are asynchronous and a classic Wishbone master.
// Overview of operation
// R1: Detection runs contact, primary, then secondary stages
// R2: Divider adapters map to 2.1A, 1A, 2.4A
// R3: Detection completion pulses the interrupt output once
// R4: Standard ports load 500mA/1.5A/3.0A and codes
// R5: Dividers code 110; unknown adapter 500mA code 101
// R6: Forced detection reruns, updates, then self-clears
// R7: Regulator needs VBUS, source, detection, 220 ms
// R8: Any failed condition keeps high impedance, regulator off
// R9: Limit set: power good low, flags, soft-start
// R10: Battery switch off at start if charging disabled
// R11: Discharge source before charging, or by host bit
// R12: Light load uses pulse-frequency control when allowed
// R13: Optimizer enabled at reset; writing zero disables
// R14: Optimizer auto-starts on DCP, or forced always
// R15: Effective limit chooses optimizer or programmed, pin-clamped
// R16: Optimizer flag set on every status change
// R17: Optimizer seed: programmed limit or 500mA by battery
// R18: Listed events restart optimizer, status back to 01
// R19: Auto detection off skips run, keeps limit
module input_source_ctrl #(
	parameter int REG_DELAY_CYC = charger_ctrl_pkg::REG_DELAY_CYC,
	parameter int STAGE_CYC     = charger_ctrl_pkg::STAGE_CYC,
	parameter int SOFT_CYC      = charger_ctrl_pkg::SOFT_CYC,
	parameter int STEP_CYC      = charger_ctrl_pkg::STEP_CYC
) (
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     reset_n,
	// Wishbone slave
	input  wire logic                     cyc_i,
	input  wire logic                     stb_i,
	input  wire logic                     we_i,
	input  wire logic [7:0]               adr_i,
	input  wire logic [31:0]              dat_i,
	input  wire logic [3:0]               sel_i,
	output logic      [31:0]              dat_o,
	output logic                          ack_o,
	// Analog front end
	input  wire charger_ctrl_pkg::sense_t sense,
	input  wire logic [5:0]               externalLimitPin,
	// Power stage control
	output logic                          internalRegulator,
	output logic                          highImpedanceMode,
	output logic                          powerGood_n,
	output logic                          converterEnable,
	output logic                          softStart,
	output logic                          batterySwitch,
	output logic                          batteryDischargeSource,
	output logic                          pfmMode,
	output logic      [5:0]               effectiveLimit,
	// Host notification
	output logic                          intPulse,
	output logic                          irq
);

	localparam int CW = charger_ctrl_pkg::CNT_W;
	localparam logic [CW-1:0] DLY = CW'(REG_DELAY_CYC);
	localparam logic [CW-1:0] STG = CW'(STAGE_CYC - 1);
	localparam logic [CW-1:0] SFT = CW'(SOFT_CYC);
	localparam logic [CW-1:0] STP = CW'(STEP_CYC - 1);

	// Refuse counts the counters cannot hold
	if (REG_DELAY_CYC < 1 || REG_DELAY_CYC >= 2**CW || STAGE_CYC < 1 || STAGE_CYC >= 2**CW ||
		SOFT_CYC < 1 || SOFT_CYC >= 2**CW || STEP_CYC < 1 || STEP_CYC >= 2**CW) begin : g_bad
		$error("input_source_ctrl: count parameter out of range");
	end

	charger_ctrl_pkg::sense_t     syncA_r, s;
	logic [5:0]                   extA_r, extLim;
	charger_ctrl_pkg::ctrl_t      ctrl_r, ctrlNxt, ctrlWr;
	charger_ctrl_pkg::status_t    statusWord;
	charger_ctrl_pkg::det_state_t det_r, detNxt;
	logic [5:0]                   inputCurrentLimit_r, curLimNxt, resLim_r, resLimNxt;
	logic [7:0]                   inputVoltageLimit_r;
	logic [2:0]                   sourceTypeCode_r, resCode_r, resCodeNxt;
	logic [5:0]                   optimizerLimit_r, optLimNxt, divLim, baseLim;
	logic [1:0]                   optimizerStatus_r, optStatNxt;
	logic [CW-1:0]                stgCnt_r, dlyCnt_r, softCnt_r, stepCnt_r;
	logic [charger_ctrl_pkg::IRQ_W-1:0] irqStat_r, irqNxt, irqEv, mask_r;
	logic [31:0]                  rdMux;
	logic                         ack_r, detDone_r, highZPrev_r, ovpPrev_r;
	logic                         req, wrEn, rdEn, hitCtrl, hitCur, hitVol, hitStat, hitIrq;
	logic                         hitMask, wrCtrl, wrCur, curChg, volChg, stageEnd, stepEnd;
	logic                         vbusUp, needRun, detGo, detSkip, detFin, isDiv;
	logic                         vbusOk, regCond, convNxt, softRun, optStart, autoDcp;
	logic                         highZToggle, ovpRise;

	// Two-stage synchronisers for the analog comparators and pin code
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			syncA_r <= '0;
			s       <= '0;
			extA_r  <= '1; // Clamp open until the pin code arrives
			extLim  <= '1;
		end else begin
			syncA_r <= sense;
			s       <= syncA_r;
			extA_r  <= externalLimitPin;
			extLim  <= extA_r;
		end
	end

	// Bus decode; access takes effect on the edge that sees ack
	assign req     = cyc_i & stb_i;
	assign wrEn    = req & ack_r & we_i & sel_i[0];
	assign rdEn    = req & ack_r & ~we_i;
	assign hitCtrl = adr_i == charger_ctrl_pkg::ADR_CTRL;
	assign hitCur  = adr_i == charger_ctrl_pkg::ADR_CURLIM;
	assign hitVol  = adr_i == charger_ctrl_pkg::ADR_VOLLIM;
	assign hitStat = adr_i == charger_ctrl_pkg::ADR_STATUS;
	assign hitIrq  = adr_i == charger_ctrl_pkg::ADR_IRQ;
	assign hitMask = adr_i == charger_ctrl_pkg::ADR_MASK;
	assign wrCtrl  = wrEn & hitCtrl;
	assign wrCur   = wrEn & hitCur;
	assign ctrlWr  = dat_i[7:0];
	assign curChg  = wrCur & (dat_i[5:0] != inputCurrentLimit_r);
	assign volChg  = wrEn & hitVol & (dat_i[7:0] != inputVoltageLimit_r);
	assign ack_o   = ack_r;

	// Status word seen by software
	assign statusWord = '{zeroHi: 10'h000, effectiveLimit: effectiveLimit, zeroMid: 2'h0,
		optimizerLimit: optimizerLimit_r, highImpedanceMode: highImpedanceMode,
		regulatorOn: internalRegulator, optimizerStatus: optimizerStatus_r,
		powerGoodFlag: converterEnable, sourceTypeCode: sourceTypeCode_r};

	// Read selection; unmapped offsets read zero
	assign rdMux = hitCtrl ? {24'h000000, ctrl_r} :
		hitCur  ? {26'h0, inputCurrentLimit_r} :
		hitVol  ? {24'h000000, inputVoltageLimit_r} :
		hitStat ? statusWord :
		hitIrq  ? {29'h0, irqStat_r} :
		hitMask ? {29'h0, mask_r} : 32'h00000000;

	// Bus handshake and read data
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ack_r <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_r <= req & ~ack_r;
			if (req & ~ack_r)
				dat_o <= rdMux;
		end
	end

	// Detection launch conditions
	assign vbusUp  = s.vbusPresent & s.sourceGood & ~s.vbusOvp;
	assign needRun = vbusUp & (~detDone_r | ctrl_r.forceDetectionBit);
	assign detGo   = (det_r == charger_ctrl_pkg::DET_IDLE) & needRun &
		(ctrl_r.autoDetectionEnable | ctrl_r.forceDetectionBit);
	assign detSkip = (det_r == charger_ctrl_pkg::DET_IDLE) & needRun &
		~ctrl_r.autoDetectionEnable & ~ctrl_r.forceDetectionBit; // R19
	assign detFin   = det_r == charger_ctrl_pkg::DET_FIN;
	assign stageEnd = stgCnt_r == STG;

	// Divider adapter classification
	assign isDiv  = (s.dp2p8 & s.dm2p8) | (s.dp2p8 & s.dm2p0) | (s.dp2p0 & s.dm2p8);
	assign divLim = (s.dp2p8 & s.dm2p8) ? charger_ctrl_pkg::LIM_2A4 :
		(s.dp2p8 & s.dm2p0) ? charger_ctrl_pkg::LIM_2A1 :
		(s.dp2p0 & s.dm2p8) ? charger_ctrl_pkg::LIM_1A0 : charger_ctrl_pkg::LIM_500; // R2

	// Detection sequence
	always_comb begin
		detNxt     = det_r;
		resLimNxt  = resLim_r;
		resCodeNxt = resCode_r;
		case (det_r)
			charger_ctrl_pkg::DET_IDLE: begin
				if (detGo)
					detNxt = charger_ctrl_pkg::DET_DCD; // R1
			end
			charger_ctrl_pkg::DET_DCD: begin
				if (stageEnd && s.dataContact) begin
					detNxt = charger_ctrl_pkg::DET_PRI; // R1
				end else if (stageEnd) begin
					detNxt     = charger_ctrl_pkg::DET_FIN;
					resLimNxt  = divLim; // R2
					resCodeNxt = isDiv ? charger_ctrl_pkg::SRC_DIV : charger_ctrl_pkg::SRC_UNK; // R5
				end
			end
			charger_ctrl_pkg::DET_PRI: begin
				if (stageEnd && s.primaryHigh) begin
					detNxt = charger_ctrl_pkg::DET_SEC; // R1
				end else if (stageEnd) begin
					detNxt     = charger_ctrl_pkg::DET_FIN;
					resLimNxt  = charger_ctrl_pkg::LIM_500; // R4
					resCodeNxt = charger_ctrl_pkg::SRC_SDP;
				end
			end
			charger_ctrl_pkg::DET_SEC: begin
				if (stageEnd) begin
					detNxt     = charger_ctrl_pkg::DET_FIN;
					resLimNxt  = s.secondaryHigh ? charger_ctrl_pkg::LIM_3A0 :
						charger_ctrl_pkg::LIM_1A5; // R4
					resCodeNxt = s.secondaryHigh ? charger_ctrl_pkg::SRC_DCP :
						charger_ctrl_pkg::SRC_CDP;
				end
			end
			charger_ctrl_pkg::DET_FIN: detNxt = charger_ctrl_pkg::DET_IDLE;
			default: detNxt = charger_ctrl_pkg::DET_IDLE;
		endcase
		if (!s.vbusPresent)
			detNxt = charger_ctrl_pkg::DET_IDLE;
	end

	// Detection state, stage timer and results
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			det_r     <= charger_ctrl_pkg::DET_IDLE;
			stgCnt_r  <= '0;
			resLim_r  <= charger_ctrl_pkg::LIM_500;
			resCode_r <= charger_ctrl_pkg::SRC_NONE;
			detDone_r <= 1'b0;
			intPulse  <= 1'b0;
		end else begin
			det_r     <= detNxt;
			stgCnt_r  <= (detNxt != det_r) ? '0 : stgCnt_r + 1'b1;
			resLim_r  <= resLimNxt;
			resCode_r <= resCodeNxt;
			detDone_r <= s.vbusPresent & (detDone_r | detFin | detSkip);
			intPulse  <= detFin; // R3
		end
	end

	// Control register: hardware clears self-clearing bits, a write of 1 wins
	always_comb begin
		ctrlNxt = ctrl_r;
		if (wrCtrl)
			ctrlNxt = ctrlWr;
		if (detFin && !(wrCtrl && ctrlWr.forceDetectionBit))
			ctrlNxt.forceDetectionBit = 1'b0; // R6
		if ((optStart || !ctrl_r.optimizerEnable) && !(wrCtrl && ctrlWr.forceOptimizerBit))
			ctrlNxt.forceOptimizerBit = 1'b0;
	end

	// Programmed limit: detection result loads, a host write follows it
	always_comb begin
		curLimNxt = inputCurrentLimit_r;
		if (detFin)
			curLimNxt = resLim_r; // R4
		if (wrCur)
			curLimNxt = dat_i[5:0];
	end

	// Software registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r              <= charger_ctrl_pkg::CTRL_RST; // R13
			inputCurrentLimit_r <= charger_ctrl_pkg::LIM_500;
			inputVoltageLimit_r <= charger_ctrl_pkg::VLIM_RST;
			mask_r              <= '0;
			sourceTypeCode_r    <= charger_ctrl_pkg::SRC_NONE;
		end else begin
			ctrl_r              <= ctrlNxt;
			inputCurrentLimit_r <= curLimNxt;
			if (wrEn && hitVol)
				inputVoltageLimit_r <= dat_i[7:0];
			if (wrEn && hitMask)
				mask_r <= dat_i[charger_ctrl_pkg::IRQ_W-1:0];
			if (!s.vbusPresent)
				sourceTypeCode_r <= charger_ctrl_pkg::SRC_NONE;
			else if (detFin)
				sourceTypeCode_r <= resCode_r; // R5
		end
	end

	// Start-up gating of regulator and converter
	assign vbusOk  = s.buckMode ? ~s.vbusPresent : s.vbusPresent;
	assign regCond = vbusOk & s.sourceGood & ~s.vbusOvp & detDone_r &
		~ctrl_r.highImpedanceRequest; // R7
	assign convNxt = internalRegulator & detDone_r & ~s.buckMode; // R9
	assign softRun = converterEnable & (softCnt_r != SFT);
	assign softStart = softRun;

	// Delay, soft-start and power stage outputs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dlyCnt_r               <= '0;
			softCnt_r              <= '0;
			internalRegulator      <= 1'b0;
			highImpedanceMode      <= 1'b1;
			converterEnable        <= 1'b0;
			powerGood_n            <= 1'b1;
			batterySwitch          <= 1'b1;
			batteryDischargeSource <= 1'b0;
			pfmMode                <= 1'b0;
		end else begin
			dlyCnt_r  <= !regCond ? '0 : (dlyCnt_r == DLY) ? dlyCnt_r : dlyCnt_r + 1'b1; // R7
			softCnt_r <= !converterEnable ? '0 : softRun ? softCnt_r + 1'b1 : softCnt_r;
			internalRegulator      <= regCond & (dlyCnt_r == DLY); // R8
			highImpedanceMode      <= ~(regCond & (dlyCnt_r == DLY)); // R8
			converterEnable        <= convNxt; // R9
			powerGood_n            <= ~convNxt; // R9
			batterySwitch          <= ~(convNxt & ~ctrl_r.chargeEnable); // R10
			batteryDischargeSource <= ctrl_r.dischargeSourceEnable |
				(softRun & ctrl_r.chargeEnable); // R11
			pfmMode <= convNxt & s.lightLoad & (s.batBelowSysMin | ~ctrl_r.chargeEnable); // R12
		end
	end

	// Optimizer start and restart events
	assign highZToggle = ctrl_r.highImpedanceRequest ^ highZPrev_r;
	assign ovpRise  = s.vbusOvp & ~ovpPrev_r;
	assign autoDcp  = detFin & (resCode_r == charger_ctrl_pkg::SRC_DCP); // R14
	assign optStart = ctrl_r.optimizerEnable & (detDone_r | detFin) &
		(ctrl_r.forceOptimizerBit | autoDcp | highZToggle | curChg | volChg | ovpRise); // R18
	assign stepEnd  = stepCnt_r == STP;

	// Optimizer search
	always_comb begin
		optStatNxt = optimizerStatus_r;
		optLimNxt  = optimizerLimit_r;
		if (!ctrl_r.optimizerEnable) begin
			optStatNxt = charger_ctrl_pkg::OPT_OFF; // R13
		end else if (optStart) begin
			optStatNxt = charger_ctrl_pkg::OPT_RUN; // R18
			optLimNxt  = s.batBelowSysMin ? inputCurrentLimit_r : charger_ctrl_pkg::LIM_500; // R17
		end else if (optimizerStatus_r == charger_ctrl_pkg::OPT_RUN && stepEnd) begin
			if (s.inVoltageLimit) begin
				if (optimizerLimit_r > charger_ctrl_pkg::LIM_500)
					optLimNxt = optimizerLimit_r - 6'h01;
				optStatNxt = charger_ctrl_pkg::OPT_DONE; // R16
			end else if (optimizerLimit_r < inputCurrentLimit_r) begin
				optLimNxt = optimizerLimit_r + 6'h01; // R16
			end else begin
				optStatNxt = charger_ctrl_pkg::OPT_DONE;
			end
		end
	end

	// Effective limit: optimizer or programmed, then pin clamp
	assign baseLim = ctrl_r.optimizerEnable ? optimizerLimit_r : inputCurrentLimit_r; // R15
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			optimizerStatus_r <= charger_ctrl_pkg::OPT_OFF;
			optimizerLimit_r  <= charger_ctrl_pkg::LIM_500;
			stepCnt_r         <= '0;
			highZPrev_r       <= 1'b0;
			ovpPrev_r         <= 1'b0;
			effectiveLimit    <= charger_ctrl_pkg::LIM_500;
		end else begin
			optimizerStatus_r <= optStatNxt;
			optimizerLimit_r  <= optLimNxt;
			stepCnt_r   <= (optStart || stepEnd) ? '0 : stepCnt_r + 1'b1;
			highZPrev_r <= ctrl_r.highImpedanceRequest;
			ovpPrev_r   <= s.vbusOvp;
			effectiveLimit <= (ctrl_r.limitPinEnable && extLim < baseLim) ? extLim : baseLim; // R15
		end
	end

	// Sticky events; a read clears, a new event in that cycle wins
	always_comb begin
		irqEv = '0;
		irqEv[charger_ctrl_pkg::IRQ_DET] = detFin;
		irqEv[charger_ctrl_pkg::IRQ_OPT] = optStatNxt != optimizerStatus_r; // R16
		irqEv[charger_ctrl_pkg::IRQ_PWR] = convNxt & ~converterEnable;
		irqNxt = ((rdEn && hitIrq) ? '0 : irqStat_r) | irqEv;
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			irqStat_r <= '0;
		else
			irqStat_r <= irqNxt;
	end
	assign irq = |(irqStat_r & mask_r);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_onePulse;
		intPulse ##1 !intPulse;
	endsequence
	sequence s_softBegin;
		!powerGood_n && softStart && detDone_r;
	endsequence

	a_sec_after_pri: assert property (det_r == charger_ctrl_pkg::DET_SEC |->      // R1
		$past(det_r) inside {charger_ctrl_pkg::DET_PRI, charger_ctrl_pkg::DET_SEC})
		else $error("secondary stage not entered from primary");
	a_pri_after_dcd: assert property (det_r == charger_ctrl_pkg::DET_PRI |->      // R1
		$past(det_r) inside {charger_ctrl_pkg::DET_DCD, charger_ctrl_pkg::DET_PRI})
		else $error("primary stage not entered from contact stage");
	a_divider_one: assert property (det_r == charger_ctrl_pkg::DET_DCD && stageEnd && // R2
		!s.dataContact && s.dp2p8 && s.dm2p0 && !s.dm2p8 |=> resLim_r == charger_ctrl_pkg::LIM_2A1)
		else $error("divider limit wrong");
	a_int_pulse: assert property (detFin |=> s_onePulse) // R3
		else $error("detection pulse missing");
	a_dcp_load: assert property (detFin && resCode_r == charger_ctrl_pkg::SRC_DCP && // R4
		s.vbusPresent && !wrCur |=> inputCurrentLimit_r == charger_ctrl_pkg::LIM_3A0 &&
		sourceTypeCode_r == charger_ctrl_pkg::SRC_DCP)
		else $error("DCP result not loaded");
	a_unknown_code: assert property (det_r == charger_ctrl_pkg::DET_DCD && stageEnd && // R5
		!s.dataContact && !isDiv |=> resCode_r == charger_ctrl_pkg::SRC_UNK &&
		resLim_r == charger_ctrl_pkg::LIM_500)
		else $error("unknown adapter result wrong");
	a_force_clear: assert property (detFin && !(wrCtrl && ctrlWr.forceDetectionBit) |=> // R6
		!ctrl_r.forceDetectionBit)
		else $error("force detection bit not cleared");
	a_reg_delay: assert property ($rose(internalRegulator) |-> // R7
		$past(dlyCnt_r) == DLY && $past(regCond))
		else $error("regulator on before delay");
	a_fail_highz: assert property (!regCond |=> !internalRegulator && highImpedanceMode) // R8
		else $error("regulator on with condition failing");
	a_power_good: assert property ($rose(converterEnable) |-> s_softBegin) // R9
		else $error("converter start without power good");
	a_switch_off: assert property (converterEnable && !$past(ctrl_r.chargeEnable) |-> // R10
		!batterySwitch)
		else $error("battery switch on with charging off");
	a_disch_host: assert property (ctrl_r.dischargeSourceEnable |=> batteryDischargeSource) // R11
		else $error("discharge source not enabled");
	a_pfm_light: assert property (convNxt && s.lightLoad && !ctrl_r.chargeEnable |=> pfmMode) // R12
		else $error("light load not in pulse mode");
	a_opt_off: assert property (!ctrl_r.optimizerEnable |=> // R13
		optimizerStatus_r == charger_ctrl_pkg::OPT_OFF)
		else $error("optimizer running while disabled");
	a_opt_dcp: assert property (autoDcp && ctrl_r.optimizerEnable |=> // R14
		optimizerStatus_r == charger_ctrl_pkg::OPT_RUN)
		else $error("optimizer not started on DCP");
	a_pin_clamp: assert property (ctrl_r.limitPinEnable |=> effectiveLimit <= $past(extLim)) // R15
		else $error("limit above pin clamp");
	a_opt_flag: assert property (optStatNxt != optimizerStatus_r |=> // R16
		irqStat_r[charger_ctrl_pkg::IRQ_OPT])
		else $error("optimizer flag not set");
	a_opt_seed: assert property (optStart && !s.batBelowSysMin |=> // R17
		optimizerLimit_r == charger_ctrl_pkg::LIM_500)
		else $error("optimizer seed wrong");
	a_opt_restart: assert property (optimizerStatus_r == charger_ctrl_pkg::OPT_DONE && // R18
		ctrl_r.optimizerEnable && detDone_r && ovpRise |=>
		optimizerStatus_r == charger_ctrl_pkg::OPT_RUN)
		else $error("optimizer not restarted");
	a_skip_keep: assert property (detSkip && !wrCur |=> // R19
		$stable(inputCurrentLimit_r) && detDone_r)
		else $error("skipped detection changed limit");

endmodule

// ==== tb/adapter_model.sv ====
// Adapter model: D+/D- comparator levels for one chosen adapter kind.
// Assumes kind is held steady while a detection run is in progress.
module adapter_model (
	// Selection
	input  wire logic [2:0]          kind,
	// Comparator levels
	output charger_ctrl_pkg::sense_t dpdm
);
	// Kinds: 0 SDP, 1 CDP, 2 DCP, 3 div1, 4 div3, 5 div4, 6 unknown
	always_comb begin
		dpdm = '0;
		dpdm.dataContact = kind < 3'h3;
		dpdm.primaryHigh = kind inside {3'h1, 3'h2};
		dpdm.secondaryHigh = kind == 3'h2;
		dpdm.dp2p8 = kind inside {3'h3, 3'h5};
		dpdm.dp2p0 = kind == 3'h4;
		dpdm.dm2p8 = kind inside {3'h4, 3'h5};
		dpdm.dm2p0 = kind == 3'h3;
	end
endmodule

// ==== tb/input_source_detect_and_ico_test.sv ====
// Bench: adapter kinds, forced rerun, start-up gating, host bits.
// Assumes shortened stage and delay counts set at the instance.
module input_source_detect_and_ico_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset_n, cyc, stb, we, vbus, ack, regOn, high_impedance_mode, pwrGood_n;
	logic conv, softSt, batSw, disSrc, pfm, intPulse, irq;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, datO;
	logic [3:0] sel, misc;
	logic [2:0] kind;
	logic [5:0] effLim, extPin;
	charger_ctrl_pkg::sense_t dpdm, sense;
	int n_errors, compares, cycles, n, i;
	// Expected limit and source code per adapter kind
	logic [5:0] lims [7] = '{6'h05, 6'h0f, 6'h1e, 6'h15, 6'h0a, 6'h18, 6'h05};
	logic [2:0] codes [7] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h6, 3'h6, 3'h5};

	adapter_model adapter_model_i (.kind(kind), .dpdm(dpdm));
	// Supply levels merged onto the adapter levels
	always_comb begin
		sense = dpdm;
		{sense.vbusPresent, sense.sourceGood} = {2{vbus}};
		{sense.vbusOvp, sense.batBelowSysMin, sense.lightLoad, sense.inVoltageLimit} = misc;
	end
	input_source_ctrl #(.REG_DELAY_CYC(20), .STAGE_CYC(4), .SOFT_CYC(4), .STEP_CYC(4))
		input_source_ctrl_i (.clk_sys(clk_sys), .reset_n(reset_n), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(datO),
		.ack_o(ack), .sense(sense), .externalLimitPin(extPin), .internalRegulator(regOn),
		.highImpedanceMode(high_impedance_mode), .powerGood_n(pwrGood_n), .converterEnable(conv),
		.softStart(softSt), .batterySwitch(batSw), .batteryDischargeSource(disSrc),
		.pfmMode(pfm), .effectiveLimit(effLim), .intPulse(intPulse), .irq(irq));

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One classic Wishbone cycle, held until ack
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
		@(posedge clk_sys);
		while (ack !== 1'b1) @(posedge clk_sys);
		rdat = datO;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic waitPulse();
		for (n = 0; n < 100 && intPulse !== 1'b1; n++) @(posedge clk_sys);
		chk("intPulse", intPulse, 1'b1);
	endtask
	task automatic end_of_test();
		$display("Compares %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Clock and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		{reset_n, cyc, stb, we, adr, wdat, sel, kind, vbus, misc} = '0;
		extPin = 6'h3f;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		chk("hiz", high_impedance_mode, 1'b1);
		chk("regOn", regOn, 1'b0);
		wb(1'b0, 8'h00, 32'h0);
		chk("ctrl", rdat, 32'h96);
		wb(1'b1, 8'h14, 32'h1);
		$display("Reset test done");
		// One row per adapter kind
		for (i = 0; i < 7; i++) begin
			kind <= i[2:0];
			vbus <= 1'b1;
			waitPulse();
			@(posedge clk_sys);
			chk("irq", irq, 1'b1);
			wb(1'b0, 8'h0c, 32'h0);
			chk("code", rdat[2:0], codes[i]);
			wb(1'b0, 8'h04, 32'h0);
			chk("limit", rdat[5:0], lims[i]);
			wb(1'b0, 8'h10, 32'h0);
			@(posedge clk_sys);
			chk("irqClr", irq, 1'b0);
			if (i < 6) vbus <= 1'b0;
			repeat (4) @(posedge clk_sys);
			$display("Adapter kind %0d done", i);
		end
		// Start-up after the last detection
		for (n = 0; n < 100 && conv !== 1'b1; n++) @(posedge clk_sys);
		chk("conv", conv, 1'b1);
		chk("softSt", softSt, 1'b1);
		chk("regOn", regOn, 1'b1);
		chk("pwrGood_n", pwrGood_n, 1'b0);
		chk("batSw", batSw, 1'b1);
		wb(1'b1, 8'h00, 32'hd6);
		repeat (2) @(posedge clk_sys);
		chk("disSrc", disSrc, 1'b1);
		wb(1'b1, 8'h00, 32'h97);
		waitPulse();
		wb(1'b0, 8'h00, 32'h0);
		chk("ctrl", rdat, 32'h96);
		$display("Start-up and force test done");
		// Auto detection off keeps the programmed limit
		wb(1'b1, 8'h00, 32'h94);
		vbus <= 1'b0;
		wb(1'b1, 8'h04, 32'h0c);
		vbus <= 1'b1;
		repeat (40) @(posedge clk_sys);
		wb(1'b0, 8'h04, 32'h0);
		chk("limit", rdat[5:0], 6'h0c);
		wb(1'b0, 8'h20, 32'h0);
		chk("unmapped", rdat, 32'h0);
		$display("Bypass and unmapped test done");
		// Charging off at light load; forced search against a low pin clamp
		{misc, extPin} <= {4'h3, 6'h03};
		wb(1'b1, 8'h00, 32'h1c);
		repeat (8) @(posedge clk_sys);
		chk("batSw", batSw, 1'b0);
		chk("pfm", pfm, 1'b1);
		chk("effLim", effLim, 6'h03);
		wb(1'b0, 8'h0c, 32'h0);
		chk("optStat", rdat[5:4], 2'h2);
		chk("optLim", rdat[13:8], 6'h05);
		wb(1'b0, 8'h10, 32'h0);
		// Overvoltage restarts a finished search
		misc <= 4'ha;
		repeat (4) @(posedge clk_sys);
		wb(1'b0, 8'h0c, 32'h0);
		chk("optStat", rdat[5:4], 2'h1);
		wb(1'b0, 8'h10, 32'h0);
		chk("optFlag", rdat[1], 1'b1);
		$display("Optimizer and light load test done");
		// Reset in mid-run brings outputs and registers back to defaults
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		chk("effLim", effLim, 6'h05);
		chk("pwrGood_n", pwrGood_n, 1'b1);
		wb(1'b0, 8'h00, 32'h0);
		chk("ctrl", rdat, 32'h96);
		$display("Mid-run reset test done");
		end_of_test();
	end
endmodule
